// ==== verilog/rscd_pkg.sv ====
/*
 Shared constants, level codes and setting types of the retimer strap
 control block.
 Assumes a single 200 MHz clock and pads that report each three-level
 strap as two comparator bits.
*/
package rscd_pkg;

   // ----------------------------------------------------------------
   // Strap levels and pad comparator layout
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} rscd_lvl_e;

   // Bit positions of the two comparators of a three-level pad.
   localparam int CMP_LO = 0;
   localparam int CMP_HI = 1;

   // Index of each three-level strap in the strap arrays.
   localparam int STRAP_N = 4;
   localparam int STRAP_DEEMPH = 0;
   localparam int STRAP_EQ = 1;
   localparam int STRAP_TERM = 2;
   localparam int STRAP_SWAP = 3;

   // Bit positions of the two-level inputs in the synchroniser.
   localparam int SY_OE = 0;
   localparam int SY_DET = 1;
   localparam int SY_HOST = 2;
   localparam int SY_ADDR = 3;
   localparam int SY_CMP = 4;
   localparam int SY_W = SY_CMP + 2 * STRAP_N;

   // ----------------------------------------------------------------
   // Settings driven to the analog front end
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {DE_MINUS2, DE_ZERO} rscd_deemph_e;
   typedef enum logic [1:0] {EQ_FIXED_7P5, EQ_ADAPTIVE, EQ_FIXED_14} rscd_eq_e;
   typedef enum logic [1:0] {ST_DOWN, ST_LATCH, ST_RUN, ST_STANDBY} rscd_state_e;

   // Values held after reset, equal to the floating-pin defaults.
   localparam rscd_deemph_e RST_DEEMPH = DE_ZERO;
   localparam rscd_eq_e RST_EQ = EQ_ADAPTIVE;
   localparam rscd_lvl_e RST_SWAP = LVL_MID;
   localparam logic [1:0] RST_ADDR = 2'h0;

   // ----------------------------------------------------------------
   // Link rate window for automatic near-end termination
   // ----------------------------------------------------------------
   localparam int RATE_STEP_MBPS = 100;
   localparam int TERM_FLOOR_MBPS = 2000;
   localparam int TERM_CEIL_MBPS = 3400;
   localparam int RATE_W = 6;
   localparam logic [RATE_W-1:0] RATE_FLOOR = RATE_W'(TERM_FLOOR_MBPS / RATE_STEP_MBPS);
   localparam logic [RATE_W-1:0] RATE_CEIL = RATE_W'(TERM_CEIL_MBPS / RATE_STEP_MBPS);

   // Above the high comparator reads high, below the low one reads low,
   // between them the pin is floating at mid level.
   function automatic rscd_lvl_e tri_level(input logic [1:0] cmp);
      rscd_lvl_e lvl;
      lvl = LVL_MID;
      if (cmp[CMP_HI]) begin
         lvl = LVL_HIGH;
      end else if (!cmp[CMP_LO]) begin
         lvl = LVL_LOW;
      end
      return lvl;
   endfunction

endpackage

// ==== verilog/rscd_strap_if.sv ====
/*
 Carrier for synchronised strap pins and their decoded levels between the
 synchroniser, the level decoder and the control core.
 Assumes all three sit on the one device clock.
*/
`timescale 1ns/10ps
interface rscd_strap_if;
   logic oe;
   logic det_en;
   logic host_sel;
   logic up_addr;
   logic oe_fall;
   logic [rscd_pkg::STRAP_N-1:0][1:0] cmp;
   rscd_pkg::rscd_lvl_e [rscd_pkg::STRAP_N-1:0] lvl;

   modport sync_mp(output oe, output det_en, output host_sel, output up_addr,
                   output oe_fall, output cmp);
   modport dec_mp(input cmp, output lvl);
   modport core_mp(input oe, input det_en, input host_sel, input up_addr,
                   input oe_fall, input lvl);
endinterface

// ==== verilog/rscd_sync.sv ====
/*
 Two-stage synchroniser for every strap pin, plus detection of the falling
 edge of the operation-enable pin.
 Assumes pins that are static apart from board events and a synchronous
 active-high reset.
*/
`timescale 1ns/10ps
module rscd_sync (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [rscd_pkg::SY_W-1:0] pins_i,
   rscd_strap_if.sync_mp sif
);

   typedef struct packed {
      logic [rscd_pkg::SY_W-1:0] s1;
      logic [rscd_pkg::SY_W-1:0] s2;
      logic oe_d;
   } rscd_sync_s;

   rscd_sync_s st_r;
   rscd_sync_s st_nxt;

   // -----------------------------------------------------------------
   // Stages
   // -----------------------------------------------------------------
   // The first stage feeds only the second; the edge detector looks at
   // the second stage and its delayed copy.
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pins_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.oe_d = st_r.s2[rscd_pkg::SY_OE];
   end

   // Reset clears the enable history so that no false fall is seen.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign sif.oe = st_r.s2[rscd_pkg::SY_OE];
   assign sif.det_en = st_r.s2[rscd_pkg::SY_DET];
   assign sif.host_sel = st_r.s2[rscd_pkg::SY_HOST];
   assign sif.up_addr = st_r.s2[rscd_pkg::SY_ADDR];
   assign sif.cmp = st_r.s2[rscd_pkg::SY_W-1:rscd_pkg::SY_CMP];
   assign sif.oe_fall = st_r.oe_d & ~st_r.s2[rscd_pkg::SY_OE];

endmodule

// ==== verilog/rscd_tri_decode.sv ====
/*
 Turns the comparator pair of each three-level strap into a level code.
 Assumes comparator bits already synchronised to the device clock.
*/
`timescale 1ns/10ps
module rscd_tri_decode (
   rscd_strap_if.dec_mp sif
);

   // -----------------------------------------------------------------
   // One decoder per strap
   // -----------------------------------------------------------------
   // A comparator pair that claims high but not above low cannot occur on
   // a real pad; the high comparator wins so the result stays defined.
   for (genvar g = 0; g < rscd_pkg::STRAP_N; g++) begin : g_strap
      assign sif.lvl[g] = rscd_pkg::tri_level(sif.cmp[g]);
   end

endmodule

// ==== verilog/rscd_core.sv ====
/*
 Control core of the retimer strap logic: power state, reset on enable
 fall, signal-detect standby, and the latched front-end configuration
 taken from straps or from the configuration bus.
 Assumes straps arrive as comparator bits, the link rate as a code in
 steps of 100 Mbps, and configuration-bus writes as one-cycle strobes.
*/
// What this block does
// - Enable low powers down, high runs.
// - Enable falling edge resets whole device.
// - Detect disabled keeps termination always connected.
// - Detect enabled: no clock means standby.
// - Host-select high picks bus, low straps.
// - Strap mode blocks bus writes to straps.
// - De-emphasis strap: low -2 dB, float 0.
// - Bus mode takes de-emphasis from bus.
// - Equalizer strap: 7.5 dB, adaptive, 14 dB.
// - Bus mode equalizer strap gives address bit1.
// - Upper address strap gives address bit2.
// - Termination strap: high off, float automatic.
// - Automatic termination only above 2 Gbps.
// - Swap strap high inverts polarity, retimer only.
// - Swap strap low reverses receive lane order.
// - Floating swap strap changes nothing.
// - Three-level pads read high, low, mid.
`timescale 1ns/10ps
module rscd_core (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic op_enable_i,
   input wire logic detect_enable_pin_i,
   input wire logic host_select_i,
   input wire logic upper_address_strap_i,
   input wire logic [1:0] deemph_strap_i,
   input wire logic [1:0] equalizer_strap_addr_low_i,
   input wire logic [1:0] output_termination_strap_i,
   input wire logic [1:0] lane_swap_strap_i,
   input wire logic clock_valid_i,
   input wire logic retimer_mode_i,
   input wire logic [rscd_pkg::RATE_W-1:0] link_bitrate_i,
   input wire logic bus_wr_i,
   input wire rscd_pkg::rscd_deemph_e bus_deemph_i,
   input wire rscd_pkg::rscd_eq_e bus_eq_i,
   output logic power_down_o,
   output logic device_reset_o,
   output logic standby_o,
   output logic detect_active_o,
   output logic rx_term_connect_o,
   output logic host_mode_o,
   output rscd_pkg::rscd_deemph_e deemph_sel_o,
   output rscd_pkg::rscd_eq_e eq_sel_o,
   output logic tx_term_auto_o,
   output logic tx_term_on_o,
   output logic lane_reverse_o,
   output logic polarity_invert_o,
   output logic [1:0] addr_bits_o
);

   typedef struct packed {
      rscd_pkg::rscd_state_e st;
      logic host;
      rscd_pkg::rscd_deemph_e de;
      rscd_pkg::rscd_eq_e eq;
      logic term_dis;
      rscd_pkg::rscd_lvl_e swap;
      logic term_on;
      logic lane_rev;
      logic pol_inv;
      logic [1:0] addr;
      logic dev_rst;
      logic det;
   } rscd_core_s;

   localparam rscd_core_s CORE_RST = '{
      st: rscd_pkg::ST_DOWN,
      host: 1'b0,
      de: rscd_pkg::RST_DEEMPH,
      eq: rscd_pkg::RST_EQ,
      term_dis: 1'b0,
      swap: rscd_pkg::RST_SWAP,
      term_on: 1'b0,
      lane_rev: 1'b0,
      pol_inv: 1'b0,
      addr: rscd_pkg::RST_ADDR,
      dev_rst: 1'b0,
      det: 1'b0
   };

   rscd_core_s st_r;
   rscd_core_s st_nxt;
   logic rate_in_window;

   rscd_strap_if sif();

   // -----------------------------------------------------------------
   // Pin capture and level decode
   // -----------------------------------------------------------------
   // Straps pass two flops before use so a slow or bouncing pin cannot
   // put the core into an undefined state.
   rscd_sync u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .pins_i({lane_swap_strap_i, output_termination_strap_i, equalizer_strap_addr_low_i,
               deemph_strap_i, upper_address_strap_i, host_select_i,
               detect_enable_pin_i, op_enable_i}),
      .sif(sif.sync_mp)
   );

   rscd_tri_decode u_dec (
      .sif(sif.dec_mp)
   );

   // The window is open above 2 Gbps and up to 3.4 Gbps inclusive.
   assign rate_in_window = (link_bitrate_i > rscd_pkg::RATE_FLOOR) &&
                           (link_bitrate_i <= rscd_pkg::RATE_CEIL);

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.dev_rst = 1'b0;
      st_nxt.det = sif.det_en;
      if (sif.oe_fall) begin
         // Falling enable wipes every setting back to its default.
         st_nxt = CORE_RST;
         st_nxt.dev_rst = 1'b1;
         st_nxt.det = sif.det_en;
      end else begin
         case (st_r.st)
            rscd_pkg::ST_DOWN: begin
               if (sif.oe) begin
                  st_nxt.st = rscd_pkg::ST_LATCH;
               end
            end
            rscd_pkg::ST_LATCH: begin
               // Straps are sampled once here; later pin noise is ignored.
               st_nxt.host = sif.host_sel;
               st_nxt.addr[1] = sif.up_addr;
               st_nxt.addr[0] = sif.host_sel &&
                                (sif.lvl[rscd_pkg::STRAP_EQ] == rscd_pkg::LVL_HIGH);
               if (!sif.host_sel) begin
                  // Reserved high de-emphasis falls back to the 0 dB default.
                  st_nxt.de = (sif.lvl[rscd_pkg::STRAP_DEEMPH] == rscd_pkg::LVL_LOW) ?
                              rscd_pkg::DE_MINUS2 : rscd_pkg::DE_ZERO;
                  case (sif.lvl[rscd_pkg::STRAP_EQ])
                     rscd_pkg::LVL_LOW: st_nxt.eq = rscd_pkg::EQ_FIXED_7P5;
                     rscd_pkg::LVL_HIGH: st_nxt.eq = rscd_pkg::EQ_FIXED_14;
                     default: st_nxt.eq = rscd_pkg::EQ_ADAPTIVE;
                  endcase
               end
               // Reserved low termination acts as the automatic default.
               st_nxt.term_dis = (sif.lvl[rscd_pkg::STRAP_TERM] == rscd_pkg::LVL_HIGH);
               st_nxt.swap = sif.lvl[rscd_pkg::STRAP_SWAP];
               st_nxt.st = rscd_pkg::ST_RUN;
            end
            rscd_pkg::ST_RUN: begin
               if (sif.det_en && !clock_valid_i) begin
                  st_nxt.st = rscd_pkg::ST_STANDBY;
               end
            end
            rscd_pkg::ST_STANDBY: begin
               if (!sif.det_en || clock_valid_i) begin
                  st_nxt.st = rscd_pkg::ST_RUN;
               end
            end
            default: begin
               st_nxt.st = rscd_pkg::ST_DOWN;
            end
         endcase
         // Bus writes land only in bus mode; in strap mode the strapped
         // settings are out of reach of the bus.
         if (st_r.host && bus_wr_i && (st_r.st == rscd_pkg::ST_RUN ||
                                       st_r.st == rscd_pkg::ST_STANDBY)) begin
            st_nxt.de = bus_deemph_i;
            st_nxt.eq = bus_eq_i;
         end
         // Polarity inversion follows the live retimer mode so a mode change
         // needs no relatch; lane reversal does not depend on the mode.
         st_nxt.lane_rev = (st_r.swap == rscd_pkg::LVL_LOW);
         st_nxt.pol_inv = (st_r.swap == rscd_pkg::LVL_HIGH) && retimer_mode_i;
         st_nxt.term_on = !st_r.term_dis && rate_in_window &&
                          (st_r.st != rscd_pkg::ST_DOWN);
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         st_r <= CORE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign power_down_o = (st_r.st == rscd_pkg::ST_DOWN);
   assign standby_o = (st_r.st == rscd_pkg::ST_STANDBY);
   assign rx_term_connect_o = !standby_o;
   assign detect_active_o = st_r.det;
   assign device_reset_o = st_r.dev_rst;
   assign host_mode_o = st_r.host;
   assign deemph_sel_o = st_r.de;
   assign eq_sel_o = st_r.eq;
   assign tx_term_auto_o = !st_r.term_dis;
   assign tx_term_on_o = st_r.term_on;
   assign lane_reverse_o = st_r.lane_rev;
   assign polarity_invert_o = st_r.pol_inv;
   assign addr_bits_o = st_r.addr;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_enable_fall;
      $fell(op_enable_i) ##1 !op_enable_i;
   endsequence

   sequence s_reset_taken;
      device_reset_o && power_down_o ##1 !device_reset_o;
   endsequence

   logic was_latch;
   assign was_latch = (st_r.st == rscd_pkg::ST_LATCH);

   // The pin crosses two flops and the edge detector, so the pulse lands two
   // cycles after the fall has been seen twice.
   enable_fall_reset_a: assert property (
      !power_down_o ##0 s_enable_fall |-> ##2 s_reset_taken)
      else $error("Enable fall did not reset the device.");

   enable_low_down_a: assert property (
      (!op_enable_i) [*4] |-> power_down_o)
      else $error("Device not powered down with enable low.");

   term_kept_on_a: assert property (
      !detect_active_o |-> rx_term_connect_o)
      else $error("Termination dropped with detect disabled.");

   standby_entry_a: assert property (
      (st_r.st == rscd_pkg::ST_RUN && sif.det_en && !clock_valid_i && !sif.oe_fall)
      |=> standby_o && !rx_term_connect_o)
      else $error("No standby without a valid clock.");

   strap_write_block_a: assert property (
      (!host_mode_o && st_r.st == rscd_pkg::ST_RUN && !sif.oe_fall)
      |=> $stable(deemph_sel_o) && $stable(eq_sel_o))
      else $error("Strap setting changed by a bus write.");

   bus_deemph_write_a: assert property (
      (host_mode_o && bus_wr_i && st_r.st == rscd_pkg::ST_RUN && !sif.oe_fall)
      |=> deemph_sel_o == $past(bus_deemph_i) && eq_sel_o == $past(bus_eq_i))
      else $error("Bus write not applied in bus mode.");

   deemph_decode_a: assert property (
      (was_latch && !sif.host_sel && !sif.oe_fall) |=> deemph_sel_o ==
      (($past(sif.lvl[rscd_pkg::STRAP_DEEMPH]) == rscd_pkg::LVL_LOW) ?
       rscd_pkg::DE_MINUS2 : rscd_pkg::DE_ZERO))
      else $error("De-emphasis strap decoded wrongly.");

   eq_fixed_high_a: assert property (
      (was_latch && !sif.host_sel && !sif.oe_fall &&
       sif.lvl[rscd_pkg::STRAP_EQ] == rscd_pkg::LVL_HIGH) |=> eq_sel_o == rscd_pkg::EQ_FIXED_14)
      else $error("Equalizer high strap not fixed 14 dB.");

   addr_low_bit_a: assert property (
      (was_latch && sif.host_sel && !sif.oe_fall) |=>
      addr_bits_o[0] == ($past(sif.lvl[rscd_pkg::STRAP_EQ]) == rscd_pkg::LVL_HIGH) &&
      addr_bits_o[1] == $past(sif.up_addr))
      else $error("Address straps not latched.");

   auto_term_rate_a: assert property (
      (!sif.oe_fall && st_r.st != rscd_pkg::ST_DOWN) |=>
      tx_term_on_o == ($past(tx_term_auto_o) && $past(rate_in_window)))
      else $error("Automatic termination wrong for link rate.");

   lane_swap_map_a: assert property (
      (!sif.oe_fall && st_r.st != rscd_pkg::ST_DOWN) |=>
      polarity_invert_o == ($past(st_r.swap == rscd_pkg::LVL_HIGH) && $past(retimer_mode_i)) &&
      lane_reverse_o == $past(st_r.swap == rscd_pkg::LVL_LOW))
      else $error("Lane swap controls do not follow the strap.");

   eq_fixed_low_a: assert property (
      (was_latch && !sif.host_sel && !sif.oe_fall &&
       sif.lvl[rscd_pkg::STRAP_EQ] == rscd_pkg::LVL_LOW) |=> eq_sel_o == rscd_pkg::EQ_FIXED_7P5)
      else $error("Equalizer low strap not fixed 7.5 dB.");

   term_strap_off_a: assert property (
      (was_latch && !sif.oe_fall) |=>
      tx_term_auto_o == ($past(sif.lvl[rscd_pkg::STRAP_TERM]) != rscd_pkg::LVL_HIGH))
      else $error("Termination strap decoded wrongly.");

   detect_off_run_a: assert property (
      (standby_o && !sif.det_en && !sif.oe_fall) |=> !standby_o && rx_term_connect_o)
      else $error("Standby held with detect disabled.");

endmodule

// ==== dv/rscd_board_model.sv ====
/*
 Board-side model of the strap block: strap resistors seen through the
 two pad comparators, and a configuration-bus host that issues writes.
 Assumes it is driven from the bench just after a falling clock edge.
*/
`timescale 1ns/10ps
module rscd_board_model (
   input wire logic clock_i,
   input wire logic [7:0] lvl_i,
   output logic [7:0] cmp_o,
   output logic bus_wr_o,
   output rscd_pkg::rscd_deemph_e bus_deemph_o,
   output rscd_pkg::rscd_eq_e bus_eq_o
);
   // ------------------------------------------------------------
   // Strap resistors
   // ------------------------------------------------------------
   // An open pin sits between both thresholds, so only the low one trips.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         case (lvl_i[2*i+:2])
            rscd_pkg::LVL_LOW: cmp_o[2*i+:2] = 2'h0;
            rscd_pkg::LVL_HIGH: cmp_o[2*i+:2] = 2'h3;
            default: cmp_o[2*i+:2] = 2'h1;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Configuration-bus host
   // ------------------------------------------------------------
   // Data is inverted once released, so stale values are never reused.
   task automatic write(input logic [1:0] d, input logic [1:0] e);
      @(negedge clock_i);
      bus_deemph_o = rscd_pkg::rscd_deemph_e'(d);
      bus_eq_o = rscd_pkg::rscd_eq_e'(e);
      bus_wr_o = 1'b1;
      @(negedge clock_i);
      bus_wr_o = 1'b0;
      bus_deemph_o = rscd_pkg::rscd_deemph_e'(~d);
      bus_eq_o = rscd_pkg::rscd_eq_e'(~e);
   endtask

   // The host stays idle until the bench asks for a write.
   initial begin
      bus_wr_o = 1'b0;
      bus_deemph_o = rscd_pkg::DE_ZERO;
      bus_eq_o = rscd_pkg::EQ_ADAPTIVE;
   end
endmodule

// ==== dv/testbench.sv ====
/*
 Self-checking bench of the strap control core.
 Assumes the board model for straps and bus writes, and one 200 MHz clock.
*/
`timescale 1ns/10ps
module testbench;
   logic clock_i, rst_i, op_en, det_en, host_sel, up_addr, clk_ok, retimer, bus_wr;
   logic [5:0] rate;
   logic [7:0] lvl, cmp;
   rscd_pkg::rscd_deemph_e bus_de, de_sel;
   rscd_pkg::rscd_eq_e bus_eq, eq_sel;
   logic pdn, drst, stby, det_act, rx_term, host_mode, t_auto, t_on, lrev, pinv;
   logic [1:0] addr;
   int err_count, samples_checked, cycles;
   int rates[5] = '{19, 20, 21, 34, 35};

   rscd_board_model board (.clock_i(clock_i), .lvl_i(lvl), .cmp_o(cmp), .bus_wr_o(bus_wr),
      .bus_deemph_o(bus_de), .bus_eq_o(bus_eq));

   rscd_core DUT (.clock_i(clock_i), .rst_i(rst_i), .op_enable_i(op_en),
      .detect_enable_pin_i(det_en), .host_select_i(host_sel), .upper_address_strap_i(up_addr),
      .deemph_strap_i(cmp[1:0]), .equalizer_strap_addr_low_i(cmp[3:2]),
      .output_termination_strap_i(cmp[5:4]), .lane_swap_strap_i(cmp[7:6]),
      .clock_valid_i(clk_ok), .retimer_mode_i(retimer), .link_bitrate_i(rate),
      .bus_wr_i(bus_wr), .bus_deemph_i(bus_de), .bus_eq_i(bus_eq), .power_down_o(pdn),
      .device_reset_o(drst), .standby_o(stby), .detect_active_o(det_act),
      .rx_term_connect_o(rx_term), .host_mode_o(host_mode), .deemph_sel_o(de_sel),
      .eq_sel_o(eq_sel), .tx_term_auto_o(t_auto), .tx_term_on_o(t_on),
      .lane_reverse_o(lrev), .polarity_invert_o(pinv), .addr_bits_o(addr));

   // ------------------------------------------------------------
   // Clock, timeout and checking tasks
   // ------------------------------------------------------------
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   // The whole run needs well under a thousand cycles.
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         conclude();
      end
   end

   task automatic chk_bit(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic chk_code(input string n, input logic [1:0] e, input logic [1:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(negedge clock_i);
   endtask

   // Raise enable and wait, bounded, for the latch to finish.
   task automatic power_up();
      int k;
      @(negedge clock_i);
      op_en = 1'b1;
      for (k = 0; k < 10 && pdn !== 1'b0; k++) @(negedge clock_i);
      chk_bit("power_down", 1'b0, pdn);
      // Power-down clears in the latch cycle; settings land one edge later and
      // the termination and lane outputs one edge after that.
      wait_n(2);
   endtask

   // Drop enable, watch the reset pulse, set new straps, power up again.
   task automatic power_cycle(input logic [7:0] l);
      int k;
      @(negedge clock_i);
      op_en = 1'b0;
      for (k = 0; k < 8 && drst !== 1'b1; k++) @(negedge clock_i);
      chk_bit("device_reset", 1'b1, drst);
      chk_bit("power_down", 1'b1, pdn);
      chk_code("deemph_reset", rscd_pkg::DE_ZERO, de_sel);
      @(negedge clock_i);
      chk_bit("reset_pulse", 1'b0, drst);
      lvl = l;
      power_up();
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      logic [1:0] s;
      rst_i = 1'b1;
      op_en = 1'b1;
      det_en = 1'b0;
      host_sel = 1'b0;
      up_addr = 1'b0;
      clk_ok = 1'b1;
      retimer = 1'b1;
      rate = 6'h1e;
      lvl = 8'h55;
      wait_n(20);
      chk_bit("power_down_in_reset", 1'b1, pdn);
      rst_i = 1'b0;
      power_up();
      chk_code("eq_default", rscd_pkg::EQ_ADAPTIVE, eq_sel);
      chk_bit("host_mode", 1'b0, host_mode);
      $display("test defaults done");

      // Every strap at each of its three levels, all four together.
      for (int i = 0; i < 3; i++) begin
         s = 2'(i);
         // The upper address strap stays open in strap mode, as the board must.
         power_cycle({4{s}});
         chk_code("deemph", (s == rscd_pkg::LVL_LOW) ? rscd_pkg::DE_MINUS2 : rscd_pkg::DE_ZERO, de_sel);
         chk_code("eq", (s == rscd_pkg::LVL_LOW) ? rscd_pkg::EQ_FIXED_7P5 :
            (s == rscd_pkg::LVL_MID) ? rscd_pkg::EQ_ADAPTIVE : rscd_pkg::EQ_FIXED_14, eq_sel);
         chk_bit("term_auto", s != rscd_pkg::LVL_HIGH, t_auto);
         chk_bit("term_on", s != rscd_pkg::LVL_HIGH, t_on);
         chk_bit("lane_reverse", s == rscd_pkg::LVL_LOW, lrev);
         chk_bit("pol_invert", s == rscd_pkg::LVL_HIGH, pinv);
         chk_code("addr", 2'h0, addr);
      end
      retimer = 1'b0;
      wait_n(3);
      chk_bit("pol_redriver", 1'b0, pinv);
      retimer = 1'b1;
      $display("test strap decode done");

      // Straps moved after the latch and bus writes in strap mode count for nothing.
      lvl = 8'h00;
      board.write(rscd_pkg::DE_MINUS2, rscd_pkg::EQ_FIXED_7P5);
      wait_n(8);
      chk_code("eq_held", rscd_pkg::EQ_FIXED_14, eq_sel);
      chk_code("deemph_held", rscd_pkg::DE_ZERO, de_sel);
      chk_bit("lane_held", 1'b0, lrev);
      $display("test strap hold done");

      // Automatic termination across the rate window edges.
      power_cycle(8'h55);
      for (int i = 0; i < 5; i++) begin
         rate = 6'(rates[i]);
         wait_n(3);
         chk_bit("term_rate", rates[i] > 20 && rates[i] <= 34, t_on);
      end
      $display("test termination done");

      // Bus mode: address from straps, settings from bus writes.
      host_sel = 1'b1;
      up_addr = 1'b1;
      power_cycle(8'h59);
      chk_bit("host_mode", 1'b1, host_mode);
      chk_code("addr_bus", 2'h3, addr);
      chk_code("eq_unwritten", rscd_pkg::EQ_ADAPTIVE, eq_sel);
      board.write(rscd_pkg::DE_MINUS2, rscd_pkg::EQ_FIXED_14);
      chk_code("deemph_bus", rscd_pkg::DE_MINUS2, de_sel);
      chk_code("eq_bus", rscd_pkg::EQ_FIXED_14, eq_sel);
      board.write(rscd_pkg::DE_ZERO, rscd_pkg::EQ_FIXED_7P5);
      chk_code("deemph_bus2", rscd_pkg::DE_ZERO, de_sel);
      chk_code("eq_bus2", rscd_pkg::EQ_FIXED_7P5, eq_sel);
      $display("test bus mode done");

      // Signal detect off never stands by; on, a missing clock does.
      clk_ok = 1'b0;
      wait_n(6);
      chk_bit("standby_off", 1'b0, stby);
      chk_bit("rx_term_off", 1'b1, rx_term);
      det_en = 1'b1;
      wait_n(6);
      chk_bit("detect_active", 1'b1, det_act);
      chk_bit("standby_on", 1'b1, stby);
      chk_bit("rx_term_on", 1'b0, rx_term);
      clk_ok = 1'b1;
      wait_n(2);
      chk_bit("standby_clock", 1'b0, stby);
      $display("test detect done");
      conclude();
   end
endmodule
